// ---- core/sdse_channel.sv ----
// one servo amplifier channel: safety, state, loop selection, coupling, encoder simulation
`include "sdse_defines.svh"
`default_nettype none
module sdse_channel (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_SRST,
    // controller inputs
    input wire logic I_ENABLE,
    input wire logic I_CUR_LIMIT_SEL,
    input wire logic signed [11:0] I_DEMAND,
    // own configuration
    input wire logic I_CFG_MODE_CURRENT,
    input wire logic I_CFG_ZERO_CHECK_EN,
    input wire logic [2:0] I_CFG_RES_SEL,
    input wire logic I_CFG_FAULT_ACT_HIGH,
    input wire logic I_CFG_WARN_ACT_HIGH,
    input wire logic [15:0] I_CFG_IMAX_LO,
    input wire logic [15:0] I_CFG_IMAX_HI,
    input wire logic I_CFG_IS_BOOSTER,
    input wire logic I_CFG_BOOST_INVERT,
    // parameters from the master channel (used when booster)
    input wire logic I_MST_MODE_CURRENT,
    input wire logic I_MST_ZERO_CHECK_EN,
    input wire logic [15:0] I_MST_IMAX,
    input wire logic signed [15:0] I_MST_CUR_CMD,
    // monitors and feedback
    input wire logic [3:0] I_MON_CRIT,
    input wire logic [3:0] I_MON_OOS,
    input wire logic signed [15:0] I_VEL,
    input wire logic signed [15:0] I_CUR_MEAS,
    input wire logic signed [31:0] I_POS_UM,
    // power stage
    output logic O_MOTOR_EN,
    output logic signed [15:0] O_CUR_CMD,
    output logic signed [15:0] O_VOLT_CMD,
    output logic [15:0] O_IMAX_ACT,
    // signalling
    output logic O_FAULT,
    output logic O_WARN,
    output logic O_ENC_OVERSPEED,
    output logic O_ENABLE_DENIED,
    output logic [1:0] O_STATE,
    // simulated encoder
    output logic O_ENC_A,
    output logic O_ENC_B
);
    // ======================================================================
    // configuration in force (booster follows the master)
    // ======================================================================
    logic mode_current;
    logic zero_check_en;
    logic [15:0] imax_sel;

    // a booster ignores its own mode, zero check and current limit settings while coupled
    always_comb begin
        mode_current = I_CFG_IS_BOOSTER ? I_MST_MODE_CURRENT : I_CFG_MODE_CURRENT;
        zero_check_en = I_CFG_IS_BOOSTER ? I_MST_ZERO_CHECK_EN : I_CFG_ZERO_CHECK_EN;
        if (I_CFG_IS_BOOSTER) begin
            imax_sel = I_MST_IMAX;
        end else begin
            imax_sel = I_CUR_LIMIT_SEL ? I_CFG_IMAX_HI : I_CFG_IMAX_LO;
        end
    end

    // ======================================================================
    // enable check and channel state
    // ======================================================================
    sdse_pkg::sdse_state_e state_r;
    sdse_pkg::sdse_state_e state_nxt;
    logic en_prev_r;
    logic en_prev_nxt;
    logic denied_r;
    logic denied_nxt;
    logic en_rise;
    logic demand_ok;
    logic any_oos;
    localparam logic signed [11:0] DEMAND_THR = 12'(`SDSE_DEMAND_THR);

    assign en_rise = I_ENABLE & ~en_prev_r;
    assign any_oos = |I_MON_OOS;
    // the check may be switched off, then any demand level is accepted
    assign demand_ok = ~zero_check_en | ((I_DEMAND >= -DEMAND_THR) && (I_DEMAND <= DEMAND_THR));

    // error beats everything; a refused enable waits for the next activation
    always_comb begin
        state_nxt = state_r;
        en_prev_nxt = I_ENABLE;
        denied_nxt = denied_r & I_ENABLE;
        case (state_r)
            sdse_pkg::ST_DISABLED: begin
                if (en_rise) begin
                    if (demand_ok) begin
                        state_nxt = sdse_pkg::ST_RUNNING;
                    end else begin
                        denied_nxt = 1'b1;
                    end
                end
            end
            sdse_pkg::ST_RUNNING: begin
                if (!I_ENABLE) begin
                    state_nxt = sdse_pkg::ST_DISABLED;
                end
            end
            sdse_pkg::ST_ERROR: begin
                if (!any_oos && !I_ENABLE) begin
                    state_nxt = sdse_pkg::ST_DISABLED;
                end
            end
            default: begin
                state_nxt = sdse_pkg::ST_DISABLED;
            end
        endcase
        if (any_oos) begin
            state_nxt = sdse_pkg::ST_ERROR;
            denied_nxt = 1'b0;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            state_r <= sdse_pkg::ST_DISABLED;
            en_prev_r <= 1'b0;
            denied_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            en_prev_r <= en_prev_nxt;
            denied_r <= denied_nxt;
        end
    end

    // ======================================================================
    // current and voltage commands
    // ======================================================================
    logic motor_en_r;
    logic motor_en_nxt;
    logic signed [15:0] cur_cmd_r;
    logic signed [15:0] cur_cmd_nxt;
    logic signed [15:0] volt_cmd_r;
    logic signed [15:0] volt_cmd_nxt;
    logic [15:0] imax_r;
    logic [15:0] imax_nxt;
    logic signed [19:0] cur_dem;
    logic signed [19:0] cur_lim;
    logic signed [19:0] cur_sel;
    logic signed [19:0] volt_raw;
    logic signed [19:0] lim_pos;

    // the position loop lives in the outside controller; only inner loops here
    always_comb begin
        motor_en_nxt = (state_nxt == sdse_pkg::ST_RUNNING) & I_ENABLE & ~any_oos;
        imax_nxt = imax_sel;
        lim_pos = {4'h0, imax_sel};
        if (mode_current) begin
            cur_dem = 20'(I_DEMAND) <<< `SDSE_CUR_SCALE_SHIFT;
        end else begin
            cur_dem = (20'(I_DEMAND) - 20'(I_VEL)) <<< `SDSE_VEL_GAIN_SHIFT;
        end
        if (cur_dem > lim_pos) begin
            cur_lim = lim_pos;
        end else if (cur_dem < -lim_pos) begin
            cur_lim = -lim_pos;
        end else begin
            cur_lim = cur_dem;
        end
        // booster does not compute; it reuses the master command, maybe mirrored
        if (I_CFG_IS_BOOSTER) begin
            cur_sel = I_CFG_BOOST_INVERT ? -20'(I_MST_CUR_CMD) : 20'(I_MST_CUR_CMD);
        end else begin
            cur_sel = cur_lim;
        end
        if (!motor_en_nxt) begin
            cur_sel = 20'h00000;
        end
        cur_cmd_nxt = 16'(cur_sel);
        // current loop is always closed inside the channel
        volt_raw = (cur_sel - 20'(I_CUR_MEAS)) <<< `SDSE_CUR_GAIN_SHIFT;
        if (!motor_en_nxt) begin
            volt_cmd_nxt = `SDSE_CMD_RST;
        end else if (volt_raw > 20'sh07FFF) begin
            volt_cmd_nxt = 16'sh7FFF;
        end else if (volt_raw < -20'sh08000) begin
            volt_cmd_nxt = 16'sh8000;
        end else begin
            volt_cmd_nxt = 16'(volt_raw);
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            motor_en_r <= 1'b0;
            cur_cmd_r <= `SDSE_CMD_RST;
            volt_cmd_r <= `SDSE_CMD_RST;
            imax_r <= `SDSE_CMD_RST;
        end else begin
            motor_en_r <= motor_en_nxt;
            cur_cmd_r <= cur_cmd_nxt;
            volt_cmd_r <= volt_cmd_nxt;
            imax_r <= imax_nxt;
        end
    end

    // ======================================================================
    // encoder simulation: follow the position in steps, edge rate limited
    // ======================================================================
    logic [5:0] res_um;
    logic signed [31:0] out_pos_r;
    logic signed [31:0] out_pos_nxt;
    logic [6:0] gap_r;
    logic [6:0] gap_nxt;
    logic ovs_r;
    logic ovs_nxt;
    logic step_r;
    logic step_nxt;
    logic dir_up_r;
    logic dir_up_nxt;
    logic signed [31:0] pos_err;
    logic [31:0] err_abs;
    logic [31:0] res_w;
    localparam logic [6:0] EDGE_GAP = 7'(`SDSE_EDGE_GAP_CYC);

    // step size lookup; unknown codes fall back to the finest step
    always_comb begin
        case (I_CFG_RES_SEL)
            `SDSE_RES_SEL_1UM: res_um = `SDSE_RES_1UM;
            `SDSE_RES_SEL_2UM: res_um = `SDSE_RES_2UM;
            `SDSE_RES_SEL_5UM: res_um = `SDSE_RES_5UM;
            `SDSE_RES_SEL_10UM: res_um = `SDSE_RES_10UM;
            `SDSE_RES_SEL_20UM: res_um = `SDSE_RES_20UM;
            `SDSE_RES_SEL_50UM: res_um = `SDSE_RES_50UM;
            default: res_um = `SDSE_RES_1UM;
        endcase
    end

    // a step is only issued once the edge gap has run out; a step still due
    // while waiting means the motion is faster than the output can follow
    always_comb begin
        res_w = {26'h0, res_um};
        pos_err = I_POS_UM - out_pos_r;
        err_abs = pos_err[31] ? 32'(-pos_err) : 32'(pos_err);
        out_pos_nxt = out_pos_r;
        gap_nxt = (gap_r != 7'h00) ? gap_r - 7'h01 : 7'h00;
        step_nxt = 1'b0;
        dir_up_nxt = dir_up_r;
        ovs_nxt = 1'b0;
        if (err_abs >= (res_w << `SDSE_DROP_SHIFT)) begin
            out_pos_nxt = I_POS_UM; // increments lost, resync
            ovs_nxt = 1'b1;
        end else if (err_abs >= res_w) begin
            if (gap_r == 7'h00) begin
                step_nxt = 1'b1;
                dir_up_nxt = ~pos_err[31];
                out_pos_nxt = pos_err[31] ? out_pos_r - 32'(res_w) : out_pos_r + 32'(res_w);
                gap_nxt = EDGE_GAP - 7'h01;
            end
            ovs_nxt = (gap_r != 7'h00) || (err_abs >= (res_w << 1));
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            out_pos_r <= `SDSE_POS_RST;
            gap_r <= 7'h00;
            step_r <= 1'b0;
            dir_up_r <= 1'b1;
            ovs_r <= 1'b0;
        end else begin
            out_pos_r <= out_pos_nxt;
            gap_r <= gap_nxt;
            step_r <= step_nxt;
            dir_up_r <= dir_up_nxt;
            ovs_r <= ovs_nxt;
        end
    end

    sdse_quad_gen u_quad (
        .i_clk(I_CLK),
        .i_srst(I_SRST),
        .i_step(step_r),
        .i_dir_up(dir_up_r),
        .o_a(O_ENC_A),
        .o_b(O_ENC_B)
    );

    // ======================================================================
    // fault and warning indication
    // ======================================================================
    logic fault_r;
    logic fault_nxt;
    logic warn_r;
    logic warn_nxt;

    // warning is a pure level, no acknowledge; polarity is configurable
    always_comb begin
        fault_nxt = (state_nxt == sdse_pkg::ST_ERROR) ~^ I_CFG_FAULT_ACT_HIGH;
        warn_nxt = (|I_MON_CRIT | ovs_nxt) ~^ I_CFG_WARN_ACT_HIGH;
    end

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            fault_r <= 1'b0;
            warn_r <= 1'b0;
        end else begin
            fault_r <= fault_nxt;
            warn_r <= warn_nxt;
        end
    end

    // ======================================================================
    // outputs, all straight from flip-flops
    // ======================================================================
    assign O_MOTOR_EN = motor_en_r;
    assign O_CUR_CMD = cur_cmd_r;
    assign O_VOLT_CMD = volt_cmd_r;
    assign O_IMAX_ACT = imax_r;
    assign O_FAULT = fault_r;
    assign O_WARN = warn_r;
    assign O_ENC_OVERSPEED = ovs_r;
    assign O_ENABLE_DENIED = denied_r;
    assign O_STATE = state_r;
endmodule : sdse_channel
`default_nettype wire

// ---- core/sdse_defines.svh ----
// constants of the servo channel: shifts, codes, reset values and timing counts
//
// Behaviour
// - motor is energized only while no error is pending and enable is active.
// - on enable activation, entry to running is refused if demand is outside -1V..1V.
// - a configuration bit switches the near-zero demand check at enable activation on or off.
// - encoder step size selectable 1, 2, 5, 10, 20 or 50 um, four edges per cycle.
// - quadrature edge rate is limited to 3 MHz, bounding trackable velocity.
// - a warning is raised when the needed edge rate exceeds the maximum; steps may drop.
// - warning output is asserted while any monitored quantity is in its critical range.
// - warning clears by itself once all monitored quantities are back in safe range.
// - any monitored quantity out of specification forces the error state and stops drive.
// - error is left only with all quantities normal and enable inactive.
// - channel is configurable for velocity control or current control.
// - velocity mode takes demand as target velocity and closes velocity and current loops.
// - current mode takes demand as target force and closes only the current loop.
// - a booster channel takes all its parameters from the master during operation; code takes only mode, zero check and current limit from it.
// - the current command is computed for the master only and applied to both channels.
// - booster drives in the same or opposite direction, chosen by actuator type.
// - the active level of fault and warning outputs is selectable.
// - a digital input selects one of two configured maximum current levels.
`ifndef SDSE_DEFINES_SVH
`define SDSE_DEFINES_SVH

// ====
// clock and encoder edge timing
// ====
`define SDSE_CLK_PERIOD_PS 32'h0000_0FA0
`define SDSE_PS_PER_MS 32'h3B9A_CA00
`define SDSE_EDGE_RATE_KHZ 32'h0000_0BB8
`define SDSE_CLK_KHZ (`SDSE_PS_PER_MS / `SDSE_CLK_PERIOD_PS)
// least spacing between two encoder edges, rounded up to whole cycles
`define SDSE_EDGE_GAP_CYC ((`SDSE_CLK_KHZ + `SDSE_EDGE_RATE_KHZ - 32'h1) / `SDSE_EDGE_RATE_KHZ)

// ====
// demand input scaling (12-bit signed code over +-10 V)
// ====
`define SDSE_DEMAND_LIM_MV 32'h0000_03E8
`define SDSE_DEMAND_FS_MV 32'h0000_2710
`define SDSE_DEMAND_FS_CODE 32'h0000_0800
`define SDSE_DEMAND_THR ((`SDSE_DEMAND_LIM_MV * `SDSE_DEMAND_FS_CODE) / `SDSE_DEMAND_FS_MV)

// ====
// encoder resolution select codes and step sizes in micrometres
// ====
`define SDSE_RES_SEL_1UM 3'h0
`define SDSE_RES_SEL_2UM 3'h1
`define SDSE_RES_SEL_5UM 3'h2
`define SDSE_RES_SEL_10UM 3'h3
`define SDSE_RES_SEL_20UM 3'h4
`define SDSE_RES_SEL_50UM 3'h5
`define SDSE_RES_1UM 6'h01
`define SDSE_RES_2UM 6'h02
`define SDSE_RES_5UM 6'h05
`define SDSE_RES_10UM 6'h0A
`define SDSE_RES_20UM 6'h14
`define SDSE_RES_50UM 6'h32
// backlog in steps beyond which increments are dropped (as a shift)
`define SDSE_DROP_SHIFT 5'h04

// ====
// loop gains (as arithmetic shifts) and reset values
// ====
`define SDSE_VEL_GAIN_SHIFT 5'h02
`define SDSE_CUR_SCALE_SHIFT 5'h03
`define SDSE_CUR_GAIN_SHIFT 5'h01
`define SDSE_CMD_RST 16'h0000
`define SDSE_POS_RST 32'h0000_0000

`endif

// ---- core/sdse_pkg.sv ----
// types shared by the servo channel modules
`default_nettype none
package sdse_pkg;
    // ====
    // channel state
    // ====
    typedef enum logic [1:0] {
        ST_DISABLED,
        ST_RUNNING,
        ST_ERROR
    } sdse_state_e;

    // signed command word toward the power stage
    typedef logic signed [15:0] sdse_cmd_t;
endpackage : sdse_pkg
`default_nettype wire

// ---- core/sdse_quad_gen.sv ----
// quadrature A/B pattern generator fed by single step pulses
`default_nettype none
module sdse_quad_gen (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // step request
    input wire logic i_step,
    input wire logic i_dir_up,
    // encoder pair
    output logic o_a,
    output logic o_b
);
    // ====
    // phase counter
    // ====
    logic [1:0] phase_r;
    logic [1:0] phase_nxt;
    logic a_r;
    logic a_nxt;
    logic b_r;
    logic b_nxt;

    // one step moves one quarter cycle, so every step is one edge
    always_comb begin
        phase_nxt = phase_r;
        if (i_step) begin
            phase_nxt = i_dir_up ? phase_r + 2'h1 : phase_r - 2'h1;
        end
        a_nxt = phase_nxt[1];
        b_nxt = phase_nxt[1] ^ phase_nxt[0]; // gray: only one line moves per step
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            phase_r <= 2'h0;
            a_r <= 1'b0;
            b_r <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            a_r <= a_nxt;
            b_r <= b_nxt;
        end
    end

    assign o_a = a_r;
    assign o_b = b_r;
endmodule : sdse_quad_gen
`default_nettype wire

// ---- dv/sdse_enc_ctrl.sv ----
// outside motion controller model: decodes the simulated encoder into a position count
`default_nettype none
module sdse_enc_ctrl (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // encoder pair
    input wire logic i_a,
    input wire logic i_b,
    // decoded position in steps, input of its own position loop
    output logic signed [31:0] o_count
);
    logic [1:0] ab_r;
    logic signed [31:0] cnt_r;
    logic signed [31:0] cnt_nxt;

    // 4x decode: each edge is one step; up when new B differs from old A
    always_comb begin
        cnt_nxt = cnt_r;
        if ({i_a, i_b} != ab_r) begin
            cnt_nxt = (ab_r[1] ^ i_b) ? cnt_r + 32'sd1 : cnt_r - 32'sd1;
        end
    end

    // registers of the decoder
    always_ff @(posedge i_clk) begin
        ab_r <= i_srst ? 2'h0 : {i_a, i_b};
        cnt_r <= i_srst ? 32'sd0 : cnt_nxt;
    end

    assign o_count = cnt_r;
endmodule : sdse_enc_ctrl
`default_nettype wire

// ---- dv/sdse_monitor.sv ----
// port checker for one servo channel
`default_nettype none
module sdse_monitor (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_SRST,
    // controller side, configuration and monitors
    input wire logic I_ENABLE,
    input wire logic I_CUR_LIMIT_SEL,
    input wire logic signed [11:0] I_DEMAND,
    input wire logic I_CFG_ZERO_CHECK_EN,
    input wire logic I_CFG_FAULT_ACT_HIGH,
    input wire logic I_CFG_WARN_ACT_HIGH,
    input wire logic [15:0] I_CFG_IMAX_LO,
    input wire logic [15:0] I_CFG_IMAX_HI,
    input wire logic I_CFG_IS_BOOSTER,
    input wire logic [15:0] I_MST_IMAX,
    input wire logic [3:0] I_MON_CRIT,
    input wire logic [3:0] I_MON_OOS,
    // channel outputs
    input wire logic O_MOTOR_EN,
    input wire logic signed [15:0] O_CUR_CMD,
    input wire logic [15:0] O_IMAX_ACT,
    input wire logic O_FAULT,
    input wire logic O_WARN,
    input wire logic O_ENC_OVERSPEED,
    input wire logic O_ENABLE_DENIED,
    input wire logic [1:0] O_STATE,
    input wire logic O_ENC_A,
    input wire logic O_ENC_B
);
    // ====
    // helper: cycles since the encoder pair last moved
    logic [1:0] ab_r;
    logic [7:0] gap_cnt_r;
    logic [7:0] gap_cnt_nxt;
    logic ab_chg;

    // saturate so a long idle never wraps into a false short gap
    always_comb begin
        ab_chg = ({O_ENC_A, O_ENC_B} != ab_r);
        gap_cnt_nxt = ab_chg ? 8'h00 : ((gap_cnt_r == 8'hFF) ? gap_cnt_r : gap_cnt_r + 8'h01);
    end

    // registers of the helper
    always_ff @(posedge I_CLK) begin
        ab_r <= {O_ENC_A, O_ENC_B};
        gap_cnt_r <= I_SRST ? 8'hFF : gap_cnt_nxt;
    end

    // ====
    // properties
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SRST);

    a_motor_gate: assert property ((!I_ENABLE || (|I_MON_OOS)) |=> !O_MOTOR_EN)
        else $error("motor on without enable or with error");
    a_cmd_idle: assert property (!O_MOTOR_EN |-> O_CUR_CMD == 16'sh0000)
        else $error("current command while off");
    a_oos_error: assert property ((|I_MON_OOS) |=> (O_STATE == 2'h2))
        else $error("no error state on fault");
    a_error_hold: assert property ((O_STATE == 2'h2) && (I_ENABLE || (|I_MON_OOS)) |=> O_STATE == 2'h2)
        else $error("error left too early");
    a_error_exit: assert property ((O_STATE == 2'h2) && !I_ENABLE && !(|I_MON_OOS) |=> O_STATE == 2'h0)
        else $error("error not left");
    a_zero_refuse: assert property ($rose(I_ENABLE) && (O_STATE == 2'h0) && I_CFG_ZERO_CHECK_EN
        && !I_CFG_IS_BOOSTER && !(|I_MON_OOS) && (I_DEMAND > 12'sd204 || I_DEMAND < -12'sd204)
        |=> (O_STATE == 2'h0) && O_ENABLE_DENIED)
        else $error("enable not refused");
    a_check_off: assert property ($rose(I_ENABLE) && (O_STATE == 2'h0) && !I_CFG_ZERO_CHECK_EN
        && !I_CFG_IS_BOOSTER && !(|I_MON_OOS) |=> (O_STATE == 2'h1) ##0 O_MOTOR_EN)
        else $error("enable not taken");
    a_no_entry: assert property ((O_STATE == 2'h0) && !$rose(I_ENABLE) && !$past(I_SRST) |=> O_STATE != 2'h1)
        else $error("running without enable rise");
    a_fault_level: assert property (!$past(I_SRST) |-> O_FAULT == ((O_STATE == 2'h2) ~^ $past(I_CFG_FAULT_ACT_HIGH)))
        else $error("fault level wrong");
    a_warn_level: assert property (!$past(I_SRST)
        |-> O_WARN == ((|$past(I_MON_CRIT) || O_ENC_OVERSPEED) ~^ $past(I_CFG_WARN_ACT_HIGH)))
        else $error("warn level wrong");
    a_imax_sel: assert property (!$past(I_SRST) |-> O_IMAX_ACT == ($past(I_CFG_IS_BOOSTER) ? $past(I_MST_IMAX)
        : ($past(I_CUR_LIMIT_SEL) ? $past(I_CFG_IMAX_HI) : $past(I_CFG_IMAX_LO))))
        else $error("current limit wrong");
    a_quad_step: assert property (!$past(I_SRST)
        |-> $countones({O_ENC_A, O_ENC_B} ^ {$past(O_ENC_A), $past(O_ENC_B)}) <= 1)
        else $error("both encoder lines moved");
    a_edge_gap: assert property (ab_chg |-> gap_cnt_r >= 8'h53)
        else $error("encoder edges too close");
endmodule : sdse_monitor
`default_nettype wire

// ---- dv/tb_top.sv ----
// self-checking bench for one servo channel
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    // signals
    logic clk, srst, en, lim_sel, mode_cur, zchk, fault_hi, warn_hi, boost, binv, m_mode, m_zchk;
    logic signed [11:0] demand;
    logic [2:0] res_sel;
    logic [15:0] imax_lo, imax_hi, m_imax, imax_act;
    logic signed [15:0] m_cmd, vel, cur_meas, cur_cmd, volt_cmd;
    logic [3:0] crit, oos;
    logic signed [31:0] pos, count, base;
    logic motor_en, fault, warn, ovs, denied, enc_a, enc_b;
    logic [1:0] state;
    int mismatches, check_count, cycles;
    typedef struct {int mc; int sel; int d; int v; int m; int cc; int vc;} sdse_row_s;
    // limits 256 low, 1024 high
    sdse_row_s rows[8] = '{'{1, 0, 16, 0, 0, 128, 256}, '{1, 0, 100, 0, 0, 256, 512},
        '{1, 1, 100, 0, 0, 800, 1600}, '{1, 1, -100, 0, 50, -800, -1700}, '{0, 1, 50, 10, 0, 160, 320},
        '{0, 0, -200, 0, 0, -256, -512}, '{1, 1, 16, 0, 50, 128, 156}, '{1, 1, 100, 0, -32000, 800, 32767}};
    int res_um[6] = '{1, 2, 5, 10, 20, 50};

    sdse_channel i_dut (.I_CLK(clk), .I_SRST(srst), .I_ENABLE(en), .I_CUR_LIMIT_SEL(lim_sel),
        .I_DEMAND(demand), .I_CFG_MODE_CURRENT(mode_cur), .I_CFG_ZERO_CHECK_EN(zchk), .I_CFG_RES_SEL(res_sel),
        .I_CFG_FAULT_ACT_HIGH(fault_hi), .I_CFG_WARN_ACT_HIGH(warn_hi), .I_CFG_IMAX_LO(imax_lo),
        .I_CFG_IMAX_HI(imax_hi), .I_CFG_IS_BOOSTER(boost), .I_CFG_BOOST_INVERT(binv),
        .I_MST_MODE_CURRENT(m_mode), .I_MST_ZERO_CHECK_EN(m_zchk), .I_MST_IMAX(m_imax), .I_MST_CUR_CMD(m_cmd),
        .I_MON_CRIT(crit), .I_MON_OOS(oos), .I_VEL(vel), .I_CUR_MEAS(cur_meas), .I_POS_UM(pos),
        .O_MOTOR_EN(motor_en), .O_CUR_CMD(cur_cmd), .O_VOLT_CMD(volt_cmd), .O_IMAX_ACT(imax_act),
        .O_FAULT(fault), .O_WARN(warn), .O_ENC_OVERSPEED(ovs), .O_ENABLE_DENIED(denied), .O_STATE(state),
        .O_ENC_A(enc_a), .O_ENC_B(enc_b));
    sdse_enc_ctrl i_ctrl (.i_clk(clk), .i_srst(srst), .i_a(enc_a), .i_b(enc_b), .o_count(count));

    // ====
    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // the whole run needs about 1800 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            mismatches++;
            summarize();
        end
    end

    // ====
    // helpers
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic chk_bit(input string name, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_bit
    task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %0d seen %0d", name, $signed(exp), $signed(got));
        end
    endtask : chk_word
    // drop enable, then raise it with the given demand; a fresh rise is always needed
    task automatic raise(input logic signed [11:0] d);
        en = 1'b0;
        tick(2);
        demand = d;
        en = 1'b1;
        tick(1);
    endtask : raise
    task automatic done(input string name);
        $display("test %s finished", name);
    endtask : done
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : summarize

    // ====
    // main sequence
    initial begin
        {srst, en, lim_sel, mode_cur, zchk, fault_hi, warn_hi, boost, binv, m_mode, m_zchk} = 11'h451;
        demand = 12'sh000;
        res_sel = 3'h0;
        {imax_lo, imax_hi, m_imax, m_cmd, vel, cur_meas} = {16'h0100, 16'h0400, 16'h0200, 16'sh012C, 32'h0};
        {crit, oos, pos} = 40'h0;
        tick(6);
        srst = 1'b0;
        tick(2);
        chk_word("state", 32'h0, state);
        chk_bit("fault", 1'b1, fault);
        raise(12'sh000);
        chk_word("state", 32'h1, state);
        foreach (rows[i]) begin
            {mode_cur, lim_sel} = {rows[i].mc[0], rows[i].sel[0]};
            {demand, vel, cur_meas} = {rows[i].d[11:0], rows[i].v[15:0], rows[i].m[15:0]};
            tick(1);
            chk_word("cur_cmd", rows[i].cc, cur_cmd);
            chk_word("volt_cmd", rows[i].vc, volt_cmd);
        end
        done("commands");
        for (int i = 0; i < 2; i++) begin
            raise(i ? -12'sd205 : 12'sd205);
            chk_word("state", 32'h0, state);
            chk_bit("denied", 1'b1, denied);
            tick(3);
            chk_bit("motor_en", 1'b0, motor_en);
            raise(i ? -12'sd204 : 12'sd204);
            chk_bit("motor_en", 1'b1, motor_en);
        end
        zchk = 1'b0;
        raise(-12'sd300);
        chk_word("state", 32'h1, state);
        en = 1'b0;
        tick(1);
        chk_bit("motor_en", 1'b0, motor_en);
        zchk = 1'b1;
        done("enable check");
        raise(12'sh000);
        oos = 4'h1;
        tick(1);
        chk_word("state", 32'h2, state);
        chk_bit("fault", 1'b0, fault);
        chk_word("cur_cmd", 32'h0, cur_cmd);
        oos = 4'h0;
        tick(2);
        chk_word("state", 32'h2, state);
        en = 1'b0;
        tick(1);
        chk_word("state", 32'h0, state);
        chk_bit("fault", 1'b1, fault);
        crit = 4'h8;
        tick(1);
        chk_bit("warn", 1'b1, warn);
        crit = 4'h0;
        tick(1);
        chk_bit("warn", 1'b0, warn);
        done("error and warning");
        foreach (res_um[i]) begin
            res_sel = 3'(i);
            base = count;
            pos = pos + res_um[i];
            tick(100);
            chk_word("count_up", base + 1, count);
            pos = pos - res_um[i];
            tick(100);
            chk_word("count_down", base, count);
            chk_bit("overspeed", 1'b0, ovs);
        end
        res_sel = 3'h0;
        pos = pos + 3;
        tick(1);
        chk_bit("overspeed", 1'b1, ovs);
        chk_bit("warn", 1'b1, warn);
        tick(260);
        chk_word("count", base + 3, count);
        pos = pos + 40;
        tick(300);
        chk_bit("warn", 1'b0, warn);
        done("encoder");
        {boost, m_zchk} = 2'b11;
        raise(12'sd300);
        chk_word("state", 32'h0, state);
        m_zchk = 1'b0;
        raise(12'sd300);
        for (int k = 0; k < 2; k++) begin
            binv = k[0];
            tick(1);
            chk_word("cur_cmd", k ? -300 : 300, cur_cmd);
            chk_word("imax_act", 32'h200, imax_act);
        end
        done("booster");
        {en, pos} = 33'h0;
        srst = 1'b1;
        tick(2);
        srst = 1'b0;
        tick(2);
        chk_word("state", 32'h0, state);
        chk_bit("motor_en", 1'b0, motor_en);
        done("reset");
        summarize();
    end
endmodule : tb_top

bind sdse_channel sdse_monitor i_mon (.I_CLK, .I_SRST, .I_ENABLE, .I_CUR_LIMIT_SEL, .I_DEMAND,
    .I_CFG_ZERO_CHECK_EN, .I_CFG_FAULT_ACT_HIGH, .I_CFG_WARN_ACT_HIGH, .I_CFG_IMAX_LO, .I_CFG_IMAX_HI,
    .I_CFG_IS_BOOSTER, .I_MST_IMAX, .I_MON_CRIT, .I_MON_OOS, .O_MOTOR_EN, .O_CUR_CMD, .O_IMAX_ACT,
    .O_FAULT, .O_WARN, .O_ENC_OVERSPEED, .O_ENABLE_DENIED, .O_STATE, .O_ENC_A, .O_ENC_B);
`default_nettype wire
